/* verilog/dlf_pkg.sv */
// Constants and types for the layer fetch and colour path.
// Assumes one 125 MHz clock and a memory reader that accepts one request per cycle.
package dlf_pkg;
	localparam int DIM_W = 12;
	localparam int POS_W = 16;
	localparam int ADDR_W = 32;
	localparam int NUM_SPR = 4;
	localparam int SPR_IDX_W = 2;
	localparam int COMP_W = 10;
	localparam int LUT_DEPTH = 256;
	localparam int COEF_W = 13;
	localparam int COEF_FRAC = 10;
	localparam int ACC_W = 28;
	localparam int ALPHA_MSB = 7;
	localparam logic [7:0] ALPHA_FULL = 8'hff;
	localparam logic [5:0] BPP_24 = 6'h18;
	localparam logic [3:0] STRIDE_ROUND = 4'h7;
	localparam int BYTE_SHIFT = 3;
	localparam int QUARTER_SHIFT = 2;
	localparam logic [COMP_W-1:0] COMP_MAX = 10'h3ff;

	typedef enum logic [2:0] {
		STEP_REV, STEP_QUARTER, STEP_HALF, STEP_ONE, STEP_TWO, STEP_FOUR
	} dlf_step_t;
	typedef enum logic [1:0] {FILL_ZERO, FILL_CONST, FILL_EDGE} dlf_fill_t;
	typedef enum logic [1:0] {CLR_BYPASS, CLR_INDEX10, CLR_INDEXRGBA, CLR_LUT} dlf_lut_mode_t;
	typedef enum logic [1:0] {MSK_PIXEL, MSK_AREA, MSK_AND, MSK_OR} dlf_mask_mode_t;

	typedef struct packed {
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
		logic [7:0] a;
	} dlf_rgba8_t;

	typedef struct packed {
		logic [ADDR_W-1:0] base;
		logic [DIM_W-1:0] stride;
		logic [DIM_W-1:0] src_width;
		logic [DIM_W-1:0] src_height;
		logic [5:0] source_pixel_width;
		logic signed [DIM_W:0] source_x_origin;
		logic signed [DIM_W:0] source_y_origin;
		logic [1:0] x_origin_fraction;
		logic [1:0] y_origin_fraction;
		dlf_step_t horiz_sample_step;
		dlf_step_t vert_sample_step;
		logic swap_scan_enable;
		logic rle_enable;
		dlf_fill_t border_fill_select;
	} dlf_fetch_cfg_t;

	typedef struct packed {
		logic enable;
		logic [ADDR_W-1:0] base;
		logic [DIM_W-1:0] width;
		logic [DIM_W-1:0] height;
		logic [DIM_W-1:0] sprite_x_place;
		logic [DIM_W-1:0] sprite_y_place;
	} dlf_sprite_t;

	typedef struct packed {
		logic [COMP_W-1:0] r;
		logic [COMP_W-1:0] g;
		logic [COMP_W-1:0] b;
		logic [7:0] a;
	} dlf_pix_t;
endpackage

/* verilog/dlf_core.sv */
// Layer fetch sample generator, sprite hit resolver and per-pixel colour path.
// Assumes requests are consumed when req_ready is high and pixels arrive in order.
`timescale 1ns/1ps
`default_nettype none
module dlf_core
	import dlf_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic frame_start,
	input wire dlf_pkg::dlf_fetch_cfg_t fetch_cfg,
	input wire logic req_ready,
	output logic req_valid,
	output logic [dlf_pkg::ADDR_W-1:0] req_addr,
	output logic req_border,
	output logic frame_busy,
	output logic no_tear_guarantee,
	output logic cfg_conflict,
	input wire dlf_pkg::dlf_sprite_t [dlf_pkg::NUM_SPR-1:0] sprites,
	input wire logic [5:0] sprite_pixel_width,
	input wire logic [dlf_pkg::DIM_W-1:0] sprite_layer_width,
	input wire logic [dlf_pkg::DIM_W-1:0] sprite_layer_height,
	input wire logic [dlf_pkg::DIM_W-1:0] sprite_x,
	input wire logic [dlf_pkg::DIM_W-1:0] sprite_y,
	input wire logic sprite_backdrop_select,
	input wire dlf_pkg::dlf_rgba8_t fill_color_value,
	output logic sprite_hit,
	output logic [dlf_pkg::SPR_IDX_W-1:0] sprite_num,
	output logic [dlf_pkg::ADDR_W-1:0] sprite_addr,
	output dlf_pkg::dlf_rgba8_t sprite_backdrop,
	input wire dlf_pkg::dlf_lut_mode_t lut_mode,
	input wire logic [3:0] palette_index_width,
	input wire logic [1:0] palette_group_bits,
	input wire logic lut_wr_en,
	input wire logic [7:0] lut_wr_addr,
	input wire logic [2:0] lut_chan_en,
	input wire logic [3*dlf_pkg::COMP_W-1:0] lut_wr_data,
	input wire logic matrix_enable,
	input wire logic signed [9*dlf_pkg::COEF_W-1:0] matrix_coefficients,
	input wire logic signed [3*dlf_pkg::COEF_W-1:0] matrix_offsets,
	input wire logic matrix_mask_gate_enable,
	input wire logic matrix_mask_polarity_invert,
	input wire logic lut_mask_gate_enable,
	input wire logic lut_mask_polarity_invert,
	input wire logic [dlf_pkg::DIM_W-1:0] overlay_x_place,
	input wire logic [dlf_pkg::DIM_W-1:0] overlay_y_place,
	input wire logic [dlf_pkg::DIM_W-1:0] overlay_width,
	input wire logic [dlf_pkg::DIM_W-1:0] overlay_height,
	input wire logic mask_generation_enable,
	input wire dlf_pkg::dlf_mask_mode_t mask_combine_select,
	input wire logic pix_valid,
	input wire dlf_pkg::dlf_rgba8_t pix_in,
	input wire logic pix_from_sprite,
	input wire logic [dlf_pkg::SPR_IDX_W-1:0] pix_sprite_num,
	input wire dlf_pkg::dlf_rgba8_t sec_pix,
	input wire logic [dlf_pkg::DIM_W-1:0] pix_x,
	input wire logic [dlf_pkg::DIM_W-1:0] pix_y,
	output logic out_valid,
	output dlf_pkg::dlf_pix_t out_pix,
	output logic out_mask
);
	import dlf_pkg::*;

	// Step in quarter pixels
	function automatic logic signed [5:0] step_q(input dlf_step_t s);
		unique case (s)
			STEP_REV: step_q = -6'sd4;
			STEP_QUARTER: step_q = 6'sd1;
			STEP_HALF: step_q = 6'sd2;
			STEP_ONE: step_q = 6'sd4;
			STEP_TWO: step_q = 6'sd8;
			STEP_FOUR: step_q = 6'sd16;
		endcase
	endfunction

	// Output dimension for a source dimension under a step
	function automatic logic [DIM_W-1:0] scaled_dim(input logic [DIM_W-1:0] d, input dlf_step_t s);
		unique case (s)
			STEP_QUARTER: scaled_dim = {d[DIM_W-3:0], 2'b00};
			STEP_HALF: scaled_dim = {d[DIM_W-2:0], 1'b0};
			STEP_TWO: scaled_dim = {1'b0, d[DIM_W-1:1]};
			STEP_FOUR: scaled_dim = {2'b00, d[DIM_W-1:2]};
			default: scaled_dim = d;
		endcase
	endfunction

	function automatic logic [DIM_W-1:0] stride_of(input logic [DIM_W-1:0] w, input logic [5:0] bpp);
		logic [DIM_W+6:0] bits;
		bits = ({7'h00, w} * {{DIM_W+1{1'b0}}, bpp}) + {{DIM_W+3{1'b0}}, STRIDE_ROUND};
		stride_of = bits[DIM_W+BYTE_SHIFT-1:BYTE_SHIFT];
	endfunction

	function automatic logic [ADDR_W-1:0] byte_addr(input logic [ADDR_W-1:0] base,
		input logic [DIM_W-1:0] row, input logic [DIM_W-1:0] stride,
		input logic [DIM_W-1:0] col, input logic [5:0] bpp);
		logic [2*DIM_W-1:0] row_off;
		logic [DIM_W+5:0] col_bits;
		row_off = row * stride;
		col_bits = {6'h00, col} * {{DIM_W{1'b0}}, bpp};
		byte_addr = base + ADDR_W'(row_off) + ADDR_W'(col_bits >> BYTE_SHIFT);
	endfunction

	function automatic logic [COMP_W-1:0] clamp(input logic signed [ACC_W-1:0] v);
		logic signed [ACC_W-1:0] s;
		s = v >>> COEF_FRAC;
		if (s < 0)
			clamp = '0;
		else if (s > ACC_W'(COMP_MAX))
			clamp = COMP_MAX;
		else
			clamp = s[COMP_W-1:0];
	endfunction

	// Fetch sample generator
	logic busy_q, busy_d;
	logic [DIM_W-1:0] cnt_i_q, cnt_i_d, cnt_o_q, cnt_o_d;
	logic req_valid_q, req_border_q;
	logic [ADDR_W-1:0] req_addr_q;

	// Run-length sources walk forward only
	wire dlf_step_t eff_hstep = (fetch_cfg.rle_enable && fetch_cfg.horiz_sample_step == STEP_REV)
		? STEP_ONE : fetch_cfg.horiz_sample_step;
	wire dlf_step_t eff_vstep = (fetch_cfg.rle_enable && fetch_cfg.vert_sample_step == STEP_REV)
		? STEP_ONE : fetch_cfg.vert_sample_step;
	wire eff_swap = fetch_cfg.swap_scan_enable && !fetch_cfg.rle_enable;
	wire [DIM_W-1:0] frame_w = scaled_dim(fetch_cfg.src_width, eff_hstep);
	wire [DIM_W-1:0] frame_h = scaled_dim(fetch_cfg.src_height, eff_vstep);
	// Swap makes the inner counter run down a column
	wire [DIM_W-1:0] out_x = eff_swap ? cnt_o_q : cnt_i_q;
	wire [DIM_W-1:0] out_y = eff_swap ? cnt_i_q : cnt_o_q;
	wire [DIM_W-1:0] inner_last = eff_swap ? frame_h - 1'b1 : frame_w - 1'b1;
	wire [DIM_W-1:0] outer_last = eff_swap ? frame_w - 1'b1 : frame_h - 1'b1;
	wire signed [POS_W+4:0] pos_x = $signed({fetch_cfg.source_x_origin, fetch_cfg.x_origin_fraction})
		+ $signed({1'b0, out_x}) * step_q(eff_hstep);
	wire signed [POS_W+4:0] pos_y = $signed({fetch_cfg.source_y_origin, fetch_cfg.y_origin_fraction})
		+ $signed({1'b0, out_y}) * step_q(eff_vstep);
	wire signed [POS_W+4:0] smp_x = pos_x >>> QUARTER_SHIFT;
	wire signed [POS_W+4:0] smp_y = pos_y >>> QUARTER_SHIFT;
	wire outside = smp_x < 0 || smp_y < 0
		|| smp_x >= $signed({1'b0, fetch_cfg.src_width})
		|| smp_y >= $signed({1'b0, fetch_cfg.src_height});
	wire edge_fill = outside && fetch_cfg.border_fill_select == FILL_EDGE;
	wire [DIM_W-1:0] cx = smp_x < 0 ? '0 : (smp_x >= $signed({1'b0, fetch_cfg.src_width})
		? fetch_cfg.src_width - 1'b1 : smp_x[DIM_W-1:0]);
	wire [DIM_W-1:0] cy = smp_y < 0 ? '0 : (smp_y >= $signed({1'b0, fetch_cfg.src_height})
		? fetch_cfg.src_height - 1'b1 : smp_y[DIM_W-1:0]);
	// One request per sample; a 24 bpp column may straddle two bursts downstream
	wire [ADDR_W-1:0] smp_addr = byte_addr(fetch_cfg.base, cy, fetch_cfg.stride, cx,
		fetch_cfg.source_pixel_width);
	wire issue = busy_q && (!req_valid_q || req_ready);
	wire inner_done = cnt_i_q == inner_last;
	wire outer_done = cnt_o_q == outer_last;

	always_comb begin
		busy_d = busy_q;
		cnt_i_d = cnt_i_q;
		cnt_o_d = cnt_o_q;
		if (frame_start) begin
			busy_d = 1'b1;
			cnt_i_d = '0;
			cnt_o_d = '0;
		end else if (issue) begin
			cnt_i_d = inner_done ? '0 : cnt_i_q + 1'b1;
			if (inner_done) begin
				cnt_o_d = outer_done ? '0 : cnt_o_q + 1'b1;
				busy_d = !outer_done;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			busy_q <= 1'b0;
			cnt_i_q <= '0;
			cnt_o_q <= '0;
			req_valid_q <= 1'b0;
			req_border_q <= 1'b0;
			req_addr_q <= '0;
		end else begin
			busy_q <= busy_d;
			cnt_i_q <= cnt_i_d;
			cnt_o_q <= cnt_o_d;
			if (issue) begin
				req_valid_q <= 1'b1;
				req_addr_q <= smp_addr;
				// Border samples carry no memory read; edge fill repeats the edge pixel
				req_border_q <= outside && !edge_fill;
			end else if (req_ready) begin
				req_valid_q <= 1'b0;
			end
		end
	end

	// Sprite hit, lowest index wins
	logic [NUM_SPR-1:0] spr_in;
	logic [SPR_IDX_W-1:0] win_idx;
	always_comb begin
		win_idx = '0;
		for (int i = NUM_SPR - 1; i >= 0; i--) begin
			spr_in[i] = sprites[i].enable && sprite_x >= sprites[i].sprite_x_place
				&& sprite_x - sprites[i].sprite_x_place < sprites[i].width
				&& sprite_y >= sprites[i].sprite_y_place
				&& sprite_y - sprites[i].sprite_y_place < sprites[i].height;
			if (spr_in[i])
				win_idx = SPR_IDX_W'(i);
		end
	end
	wire in_layer = sprite_x < sprite_layer_width && sprite_y < sprite_layer_height;
	wire dlf_sprite_t win = sprites[win_idx];
	wire [ADDR_W-1:0] spr_addr_d = byte_addr(win.base, sprite_y - win.sprite_y_place,
		stride_of(win.width, sprite_pixel_width), sprite_x - win.sprite_x_place,
		sprite_pixel_width);

	logic sprite_hit_q;
	logic [SPR_IDX_W-1:0] sprite_num_q;
	logic [ADDR_W-1:0] sprite_addr_q;
	dlf_rgba8_t backdrop_q;
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			sprite_hit_q <= 1'b0;
			sprite_num_q <= '0;
			sprite_addr_q <= '0;
			backdrop_q <= '0;
		end else begin
			sprite_hit_q <= in_layer && |spr_in;
			sprite_num_q <= win_idx;
			sprite_addr_q <= spr_addr_d;
			backdrop_q <= sprite_backdrop_select ? fill_color_value : '0;
		end
	end

	// Colour lookup table, three 10-bit channels per entry
	logic [3*COMP_W-1:0] lut_mem [LUT_DEPTH];
	always_ff @(posedge clock) begin
		for (int c = 0; c < 3; c++) begin
			if (lut_wr_en && lut_chan_en[c])
				lut_mem[lut_wr_addr][c*COMP_W +: COMP_W] <= lut_wr_data[c*COMP_W +: COMP_W];
		end
	end

	wire px_mask = pix_in.a[ALPHA_MSB];
	wire lut_gate = !lut_mask_gate_enable || (px_mask ^ lut_mask_polarity_invert);
	wire [7:0] idx_mask = 8'(({1'b0, 8'hff} << palette_index_width) ^ 9'h1ff);
	wire [7:0] grp_shift = 8'(palette_index_width);
	wire [7:0] grp_bits = 8'((pix_sprite_num >> (SPR_IDX_W - palette_group_bits))
		<< grp_shift);
	wire [7:0] pal_idx = (pix_in.r & idx_mask)
		| ((pix_from_sprite && palette_group_bits != '0) ? grp_bits : 8'h00);

	logic [3*COMP_W-1:0] ent;
	dlf_pix_t lut_px;
	logic sec_in;
	always_comb begin
		ent = lut_mem[pix_in.r];
		lut_px = {{pix_in.r, pix_in.r[7:6]}, {pix_in.g, pix_in.g[7:6]},
			{pix_in.b, pix_in.b[7:6]}, pix_in.a};
		unique case (lut_mode)
			CLR_BYPASS: ;
			CLR_INDEX10: begin
				ent = lut_mem[pal_idx];
				lut_px = {ent, pix_in.a};
			end
			CLR_INDEXRGBA: begin
				ent = lut_mem[pal_idx];
				lut_px = {ent[29:22], ent[29:28], ent[19:12], ent[19:18], ent[9:2], ent[9:8],
					ent[21:20], ent[11:10], ent[1:0], ent[21:20]};
			end
			CLR_LUT: begin
				lut_px.r = lut_mem[pix_in.r][29:20];
				lut_px.g = lut_mem[pix_in.g][19:10];
				lut_px.b = lut_mem[pix_in.b][9:0];
			end
		endcase
		if (!lut_gate && lut_mode == CLR_LUT)
			lut_px = {{pix_in.r, pix_in.r[7:6]}, {pix_in.g, pix_in.g[7:6]},
				{pix_in.b, pix_in.b[7:6]}, pix_in.a};
		sec_in = pix_x >= overlay_x_place && pix_x - overlay_x_place < overlay_width
			&& pix_y >= overlay_y_place && pix_y - overlay_y_place < overlay_height;
	end

	// Stage one: lookup result and overlay blend
	logic s1_valid_q, s1_mask_q;
	dlf_pix_t s1_pix_q;
	logic [8:0] inv_a;
	logic [COMP_W+8:0] mix [3];
	dlf_pix_t blend_px;
	logic area_mask;
	always_comb begin
		inv_a = {1'b0, ALPHA_FULL} - {1'b0, sec_pix.a};
		mix[0] = lut_px.r * inv_a + {sec_pix.r, 2'b00} * {1'b0, sec_pix.a};
		mix[1] = lut_px.g * inv_a + {sec_pix.g, 2'b00} * {1'b0, sec_pix.a};
		mix[2] = lut_px.b * inv_a + {sec_pix.b, 2'b00} * {1'b0, sec_pix.a};
		blend_px = lut_px;
		if (sec_in) begin
			blend_px.r = mix[0][COMP_W+7:8];
			blend_px.g = mix[1][COMP_W+7:8];
			blend_px.b = mix[2][COMP_W+7:8];
		end
		area_mask = sec_in && sec_pix.a[ALPHA_MSB];
	end

	logic gen_mask;
	always_comb begin
		unique case (mask_combine_select)
			MSK_PIXEL: gen_mask = px_mask;
			MSK_AREA: gen_mask = area_mask;
			MSK_AND: gen_mask = px_mask & area_mask;
			MSK_OR: gen_mask = px_mask | area_mask;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			s1_valid_q <= 1'b0;
			s1_mask_q <= 1'b0;
			s1_pix_q <= '0;
		end else begin
			s1_valid_q <= pix_valid;
			s1_pix_q <= blend_px;
			s1_mask_q <= mask_generation_enable ? gen_mask : px_mask;
		end
	end

	// Stage two: colour matrix
	logic signed [ACC_W-1:0] acc [3];
	dlf_pix_t mat_px;
	always_comb begin
		for (int r = 0; r < 3; r++) begin
			acc[r] = ACC_W'($signed(matrix_offsets[r*COEF_W +: COEF_W])) <<< COEF_FRAC;
			acc[r] = acc[r]
				+ ACC_W'($signed(matrix_coefficients[(3*r)*COEF_W +: COEF_W]) * $signed({1'b0, s1_pix_q.r}))
				+ ACC_W'($signed(matrix_coefficients[(3*r+1)*COEF_W +: COEF_W]) * $signed({1'b0, s1_pix_q.g}))
				+ ACC_W'($signed(matrix_coefficients[(3*r+2)*COEF_W +: COEF_W]) * $signed({1'b0, s1_pix_q.b}));
		end
		mat_px = {clamp(acc[0]), clamp(acc[1]), clamp(acc[2]), s1_pix_q.a};
	end
	wire mat_gate = !matrix_mask_gate_enable || (s1_mask_q ^ matrix_mask_polarity_invert);

	logic out_valid_q, out_mask_q;
	dlf_pix_t out_pix_q;
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			out_valid_q <= 1'b0;
			out_mask_q <= 1'b0;
			out_pix_q <= '0;
		end else begin
			out_valid_q <= s1_valid_q;
			out_mask_q <= s1_mask_q;
			out_pix_q <= (matrix_enable && mat_gate) ? mat_px : s1_pix_q;
		end
	end

	// Status flags
	logic no_tear_q, conflict_q;
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			no_tear_q <= 1'b1;
			conflict_q <= 1'b0;
		end else begin
			no_tear_q <= eff_hstep <= STEP_ONE && eff_vstep <= STEP_ONE && !eff_swap;
			conflict_q <= fetch_cfg.rle_enable && fetch_cfg.source_pixel_width == BPP_24
				&& fetch_cfg.horiz_sample_step == STEP_REV;
		end
	end

	assign req_valid = req_valid_q;
	assign req_addr = req_addr_q;
	assign req_border = req_border_q;
	assign frame_busy = busy_q;
	assign no_tear_guarantee = no_tear_q;
	assign cfg_conflict = conflict_q;
	assign sprite_hit = sprite_hit_q;
	assign sprite_num = sprite_num_q;
	assign sprite_addr = sprite_addr_q;
	assign sprite_backdrop = backdrop_q;
	assign out_valid = out_valid_q;
	assign out_pix = out_pix_q;
	assign out_mask = out_mask_q;
endmodule
`default_nettype wire

/* bench/dlf_mem_model.sv */
// Memory read port model for the fetch walk: grants requests at once or with stalls.
// Assumes one request per handshake; read data return is not modelled here.
`timescale 1ns/1ps
`default_nettype none
module dlf_mem_model (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic slow,
	output logic req_ready
);
	logic [1:0] stall_q;
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			stall_q <= 2'h0;
		end else begin
			stall_q <= stall_q + 2'h1;
		end
	end
	// Slow grants one cycle in four, so the walk must hold each request
	assign req_ready = !slow || (stall_q == 2'h3);
endmodule
`default_nettype wire

/* bench/dlf_core_chk.sv */
// Port assertions for the layer fetch and colour path.
// Bound into dlf_core; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dlf_core_chk
	import dlf_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic frame_start,
	input wire dlf_pkg::dlf_fetch_cfg_t fetch_cfg,
	input wire logic req_ready,
	input wire logic req_valid,
	input wire logic [dlf_pkg::ADDR_W-1:0] req_addr,
	input wire logic no_tear_guarantee,
	input wire logic cfg_conflict,
	input wire logic [dlf_pkg::DIM_W-1:0] sprite_layer_width,
	input wire logic [dlf_pkg::DIM_W-1:0] sprite_layer_height,
	input wire logic [dlf_pkg::DIM_W-1:0] sprite_x,
	input wire logic [dlf_pkg::DIM_W-1:0] sprite_y,
	input wire logic sprite_backdrop_select,
	input wire dlf_pkg::dlf_rgba8_t fill_color_value,
	input wire logic sprite_hit,
	input wire dlf_pkg::dlf_rgba8_t sprite_backdrop,
	input wire dlf_pkg::dlf_lut_mode_t lut_mode,
	input wire logic mask_generation_enable,
	input wire logic pix_valid,
	input wire dlf_pkg::dlf_rgba8_t pix_in,
	input wire logic out_valid,
	input wire dlf_pkg::dlf_pix_t out_pix,
	input wire logic out_mask
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	wire logic tear_ok = fetch_cfg.horiz_sample_step <= STEP_ONE &&
		fetch_cfg.vert_sample_step <= STEP_ONE && !fetch_cfg.swap_scan_enable;
	wire logic conf = fetch_cfg.rle_enable && fetch_cfg.source_pixel_width == BPP_24 &&
		fetch_cfg.horiz_sample_step == STEP_REV;
	wire logic outside = sprite_x >= sprite_layer_width || sprite_y >= sprite_layer_height;
	wire logic a7 = pix_in.a[ALPHA_MSB];
	wire logic idx10 = lut_mode == CLR_INDEX10;
	wire logic mgen = mask_generation_enable;

	property p_start;
		frame_start |-> ##[1:2] req_valid;
	endproperty
	a_start: assert property (p_start) else $error("no request after frame start");
	property p_hold;
		req_valid && !req_ready && !frame_start |=> req_valid && $stable(req_addr);
	endproperty
	a_hold: assert property (p_hold) else $error("request dropped before grant");
	property p_tear;
		$past(reset_n) && $stable(fetch_cfg) && !fetch_cfg.rle_enable |->
			no_tear_guarantee == $past(tear_ok);
	endproperty
	a_tear: assert property (p_tear) else $error("tearing flag wrong");
	property p_conf;
		$past(reset_n) && $stable(fetch_cfg) |-> cfg_conflict == $past(conf);
	endproperty
	a_conf: assert property (p_conf) else $error("conflict flag wrong");
	property p_backdrop;
		$past(reset_n) |-> sprite_backdrop ==
			($past(sprite_backdrop_select) ? $past(fill_color_value) : '0);
	endproperty
	a_backdrop: assert property (p_backdrop) else $error("sprite backdrop wrong");
	property p_outside;
		$past(reset_n) && $past(outside) |-> !sprite_hit;
	endproperty
	a_outside: assert property (p_outside) else $error("hit beyond sprite layer");
	property p_lat;
		$past(reset_n) && $past(reset_n, 2) |-> out_valid == $past(pix_valid, 2);
	endproperty
	a_lat: assert property (p_lat) else $error("pixel latency wrong");
	property p_mask;
		$past(reset_n) && $past(reset_n, 2) && $past(pix_valid, 2) && !$past(mgen, 2) &&
			!$past(mgen) |-> out_mask == $past(a7, 2);
	endproperty
	a_mask: assert property (p_mask) else $error("pixel mask wrong");
	property p_alpha;
		$past(reset_n) && $past(reset_n, 2) && $past(pix_valid, 2) && $past(idx10, 2) |->
			out_pix.a == $past(pix_in.a, 2);
	endproperty
	a_alpha: assert property (p_alpha) else $error("alpha not passed");
endmodule
bind dlf_core dlf_core_chk i_chk (.clock, .reset_n, .frame_start, .fetch_cfg, .req_ready,
	.req_valid, .req_addr, .no_tear_guarantee, .cfg_conflict, .sprite_layer_width,
	.sprite_layer_height, .sprite_x, .sprite_y, .sprite_backdrop_select, .fill_color_value,
	.sprite_hit, .sprite_backdrop, .lut_mode, .mask_generation_enable, .pix_valid, .pix_in,
	.out_valid, .out_pix, .out_mask);
`default_nettype wire

/* bench/dlf_core_test.sv */
// Self-checking bench for dlf_core: fetch walks, sprite queries, colour path.
// Assumes the memory model beside it and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module dlf_core_test;
	import dlf_pkg::*;
	logic clock = 1'b0, reset_n = 1'b0, frame_start = 1'b0, slow = 1'b0;
	dlf_fetch_cfg_t fetch_cfg = '0;
	dlf_sprite_t [NUM_SPR-1:0] sprites = '0;
	logic [5:0] sprite_pixel_width = 6'h04;
	logic [DIM_W-1:0] sprite_layer_width = 12'h008, sprite_layer_height = 12'h008;
	logic [DIM_W-1:0] sprite_x = '0, sprite_y = '0, pix_x = 12'h008, pix_y = '0;
	logic [DIM_W-1:0] overlay_x_place = '0, overlay_y_place = '0;
	logic [DIM_W-1:0] overlay_width = 12'h004, overlay_height = 12'h004;
	logic sprite_backdrop_select = 1'b0, lut_wr_en = 1'b0, matrix_enable = 1'b0;
	logic matrix_mask_gate_enable = 1'b0, matrix_mask_polarity_invert = 1'b0;
	logic lut_mask_gate_enable = 1'b0, lut_mask_polarity_invert = 1'b0;
	logic mask_generation_enable = 1'b0, pix_valid = 1'b0, pix_from_sprite = 1'b0;
	dlf_rgba8_t fill_color_value = 32'h1234_5678, pix_in = '0, sec_pix = '0;
	dlf_lut_mode_t lut_mode = CLR_INDEX10;
	dlf_mask_mode_t mask_combine_select = MSK_AREA;
	logic [3:0] palette_index_width = 4'h8;
	logic [1:0] palette_group_bits = '0, pix_sprite_num = '0;
	logic [7:0] lut_wr_addr = '0;
	logic [2:0] lut_chan_en = '0;
	logic [3*COMP_W-1:0] lut_wr_data = '0;
	logic signed [9*COEF_W-1:0] matrix_coefficients = '0;
	logic signed [3*COEF_W-1:0] matrix_offsets = '0;
	logic req_ready, req_valid, req_border, frame_busy, no_tear_guarantee, cfg_conflict;
	logic sprite_hit, out_valid, out_mask;
	logic [ADDR_W-1:0] req_addr, sprite_addr;
	logic [SPR_IDX_W-1:0] sprite_num;
	dlf_rgba8_t sprite_backdrop;
	dlf_pix_t out_pix;
	int n_mismatch = 0, cmp_count = 0, cycles = 0;
	logic [ADDR_W-1:0] got_a[$];
	logic got_b[$];

	dlf_core i_dut (.clock, .reset_n, .frame_start, .fetch_cfg, .req_ready, .req_valid,
		.req_addr, .req_border, .frame_busy, .no_tear_guarantee, .cfg_conflict, .sprites,
		.sprite_pixel_width, .sprite_layer_width, .sprite_layer_height, .sprite_x, .sprite_y,
		.sprite_backdrop_select, .fill_color_value, .sprite_hit, .sprite_num, .sprite_addr,
		.sprite_backdrop, .lut_mode, .palette_index_width, .palette_group_bits, .lut_wr_en,
		.lut_wr_addr, .lut_chan_en, .lut_wr_data, .matrix_enable, .matrix_coefficients,
		.matrix_offsets, .matrix_mask_gate_enable, .matrix_mask_polarity_invert,
		.lut_mask_gate_enable, .lut_mask_polarity_invert, .overlay_x_place,
		.overlay_y_place, .overlay_width, .overlay_height, .mask_generation_enable,
		.mask_combine_select, .pix_valid, .pix_in, .pix_from_sprite, .pix_sprite_num,
		.sec_pix, .pix_x, .pix_y, .out_valid, .out_pix, .out_mask);
	dlf_mem_model i_mem (.clock, .reset_n, .slow, .req_ready);

	always #4 clock = ~clock;
	always @(posedge clock) begin
		if (reset_n && req_valid && req_ready) begin
			got_a.push_back(req_addr);
			got_b.push_back(req_border);
		end
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Step in quarter pixels
	function automatic int sq(dlf_step_t s);
		case (s)
			STEP_REV: return -4;
			STEP_QUARTER: return 1;
			STEP_HALF: return 2;
			STEP_TWO: return 8;
			STEP_FOUR: return 16;
			default: return 4;
		endcase
	endfunction

	// Source is 4 x 4 at 16 bpp, stride 16 bytes
	task automatic walk(dlf_step_t hs, dlf_step_t vs, int xo, int yo, int xf, int yf,
		logic sw, logic rle, dlf_fill_t fl);
		int fw, fh, n, x, y;
		logic cm;
		logic [ADDR_W-1:0] ea[$];
		logic eb[$];
		cm = sw && !rle;
		fetch_cfg.horiz_sample_step = hs;
		fetch_cfg.vert_sample_step = vs;
		fetch_cfg.source_x_origin = 13'(xo);
		fetch_cfg.source_y_origin = 13'(yo);
		fetch_cfg.x_origin_fraction = 2'(xf);
		fetch_cfg.y_origin_fraction = 2'(yf);
		fetch_cfg.swap_scan_enable = sw;
		fetch_cfg.rle_enable = rle;
		fetch_cfg.border_fill_select = fl;
		fw = hs == STEP_REV ? 4 : 16 / sq(hs);
		fh = vs == STEP_REV ? 4 : 16 / sq(vs);
		for (int o = 0; o < (cm ? fw : fh); o++) begin
			for (int i = 0; i < (cm ? fh : fw); i++) begin
				x = (xo * 4 + xf + (cm ? o : i) * sq(hs)) >>> 2;
				y = (yo * 4 + yf + (cm ? i : o) * sq(vs)) >>> 2;
				eb.push_back((x < 0 || x > 3 || y < 0 || y > 3) && fl != FILL_EDGE);
				x = x < 0 ? 0 : (x > 3 ? 3 : x);
				y = y < 0 ? 0 : (y > 3 ? 3 : y);
				ea.push_back(32'h0000_1000 + y * 16 + x * 2);
			end
		end
		got_a.delete();
		got_b.delete();
		slow = !slow;
		frame_start = 1'b1;
		@(posedge clock);
		#1 frame_start = 1'b0;
		n = 0;
		while (got_a.size() < fw * fh && n < 2000) begin
			@(posedge clock);
			n++;
		end
		repeat (4) @(posedge clock);
		#1;
		check("count", got_a.size(), fw * fh);
		check("busy", frame_busy, 1'b0);
		if (!rle) check("tear", no_tear_guarantee, hs <= STEP_ONE && vs <= STEP_ONE && !sw);
		for (int k = 0; k < fw * fh && k < got_a.size(); k++) begin
			check("addr", got_a[k], ea[k]);
			check("border", got_b[k], eb[k]);
		end
	endtask

	task automatic spr(int x, int y, logic hit, int num, int addr);
		sprite_x = 12'(x);
		sprite_y = 12'(y);
		repeat (2) @(posedge clock);
		#1 check("hit", sprite_hit, hit);
		if (hit) check("num", sprite_num, 2'(num));
		if (hit) check("saddr", sprite_addr, 32'(addr));
	endtask

	task automatic lutw(int a, logic [29:0] d, logic [2:0] en);
		lut_wr_addr = 8'(a);
		lut_wr_data = d;
		lut_chan_en = en;
		lut_wr_en = 1'b1;
		@(posedge clock);
		#1 lut_wr_en = 1'b0;
	endtask

	// Inputs held three cycles so the two-stage result is settled
	task automatic pix(logic [7:0] r, logic [7:0] a);
		pix_in = {r, r, r, a};
		pix_valid = 1'b1;
		repeat (3) @(posedge clock);
		#1 pix_valid = 1'b0;
	endtask

	initial begin
		fetch_cfg.base = 32'h0000_1000;
		fetch_cfg.stride = 12'h010;
		fetch_cfg.src_width = 12'h004;
		fetch_cfg.src_height = 12'h004;
		fetch_cfg.source_pixel_width = 6'h10;
		sprites[0] = {1'b1, 32'h0000_2000, 12'h004, 12'h004, 12'h002, 12'h002};
		sprites[1] = {1'b1, 32'h0000_3000, 12'h005, 12'h003, 12'h004, 12'h003};
		repeat (4) @(posedge clock);
		#1 reset_n = 1'b1;
		check("rst_tear", no_tear_guarantee, 1'b1);
		check("rst_valid", req_valid, 1'b0);
		walk(STEP_ONE, STEP_ONE, 0, 0, 0, 0, 0, 0, FILL_ZERO);
		walk(STEP_REV, STEP_REV, 3, 3, 0, 0, 0, 0, FILL_ZERO);
		walk(STEP_ONE, STEP_ONE, 0, 0, 0, 0, 1, 0, FILL_ZERO);
		walk(STEP_REV, STEP_REV, 3, 3, 0, 0, 1, 0, FILL_ZERO);
		walk(STEP_ONE, STEP_ONE, 0, 0, 0, 0, 1, 1, FILL_ZERO);
		walk(STEP_HALF, STEP_QUARTER, 0, 0, 1, 2, 0, 0, FILL_EDGE);
		walk(STEP_TWO, STEP_FOUR, 0, 0, 0, 0, 0, 0, FILL_ZERO);
		walk(STEP_HALF, STEP_ONE, -1, 0, 2, 0, 0, 0, FILL_ZERO);
		walk(STEP_ONE, STEP_HALF, 0, -1, 0, 0, 0, 0, FILL_CONST);
		spr(4, 3, 1, 0, 32'h0000_2003);
		spr(7, 4, 1, 1, 32'h0000_3004);
		spr(8, 4, 0, 0, 0);
		spr(0, 0, 0, 0, 0);
		sprite_backdrop_select = 1'b1;
		@(posedge clock);
		#1 check("backdrop", sprite_backdrop, 32'h1234_5678);
		lutw(5, {10'h2a5, 10'h15a, 10'h0c3}, 3'h7);
		pix(8'h05, 8'h81);
		check("r", out_pix.r, 10'h2a5);
		check("b", out_pix.b, 10'h0c3);
		check("a", out_pix.a, 8'h81);
		check("mask1", out_mask, 1'b1);
		lutw(5, {10'h111, 10'h222, 10'h333}, 3'h3);
		pix(8'h05, 8'h7f);
		check("r_kept", out_pix.r, 10'h2a5);
		check("g_new", out_pix.g, 10'h222);
		check("mask0", out_mask, 1'b0);
		lut_mode = CLR_INDEXRGBA;
		pix(8'h05, 8'h00);
		check("a6", out_pix.a[7:2], 6'h1b);
		lut_mode = CLR_INDEX10;
		palette_index_width = 4'h4;
		palette_group_bits = 2'h1;
		pix_from_sprite = 1'b1;
		pix_sprite_num = 2'h2;
		lutw(21, {10'h0f0, 10'h00f, 10'h0ff}, 3'h7);
		pix(8'h05, 8'h00);
		check("group", out_pix.r, 10'h0f0);
		pix_from_sprite = 1'b0;
		mask_generation_enable = 1'b1;
		sec_pix.a = 8'h80;
		pix_x = 12'h001;
		pix(8'h05, 8'h00);
		check("area_in", out_mask, 1'b1);
		pix_x = 12'h009;
		pix(8'h05, 8'h00);
		check("area_out", out_mask, 1'b0);
		matrix_enable = 1'b1;
		matrix_offsets = {13'h0003, 13'h0005, 13'h1fff};
		pix(8'h05, 8'h00);
		check("mat_r", out_pix.r, 10'h000);
		check("mat_g", out_pix.g, 10'h005);
		tally_and_finish();
	end
endmodule
`default_nettype wire
